// *** ais_pkg.sv ***
// Package with register map, field layout and carrier types of the block.
// Contract
// - The sample A positive field is a plain binary index of analog inputs 0 to 31.
// - The sample B positive field sits in bits 12 to 8 and decodes like sample A.
// - Sample A negative input is analog input 1 when bit 7 is set, else the negative reference.
// - Bits 14-13 and 6-5 of the channel 0 select register read zero and ignore writes.
// - Reset clears every implemented field of all three registers.
// - The high scan register bit n includes analog input n plus 16.
// - The low scan register bit n includes analog input n.
// - Scanning includes every input whose scan bit is one.
// - Scanning skips every input whose scan bit is zero.
// - All scan bits stay writable; a scanned input without a pin converts the negative reference.
package ais_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_CHANNEL0_INPUT_SELECT = 12'h000;
   localparam logic [11:0] ADDR_SCAN_INCLUDE_HIGH     = 12'h004;
   localparam logic [11:0] ADDR_SCAN_INCLUDE_LOW      = 12'h008;
   localparam logic [11:0] ADDR_SCAN_STEP             = 12'h00c;

   localparam logic [15:0] RESET_VALUE        = 16'h0000;
   localparam logic [15:0] SELECT_WRITE_MASK  = 16'h9f9f;
   localparam int          NUM_INPUTS         = 32;
   localparam int          POS_A_LSB          = 0;
   localparam int          NEG_A_BIT          = 7;
   localparam int          POS_B_LSB          = 8;
   localparam int          NEG_B_BIT          = 15;
   localparam logic [4:0]  NEG_INPUT_INDEX    = 5'h01;

   // Number of analog inputs bonded out on this part.
   localparam logic [5:0]  PIN_COUNT_DEFAULT  = 6'h20;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [4:0] sample_a_positive_select;
      logic       sample_a_negative_select;
      logic [4:0] sample_b_positive_select;
      logic       sample_b_negative_select;
   } ais_mux_type;

   typedef struct packed {
      logic       valid;
      logic [4:0] analog_input_n;
      logic       use_negative_reference;
   } ais_scan_type;

endpackage : ais_pkg

// *** ais_scan_pick.sv ***
// Search for the next included analog input after a given position.
`timescale 1ns/1ps
module ais_scan_pick (
   // Scan state
   input  wire logic [31:0] mask,
   input  wire logic [4:0]  current,
   // Result
   output logic             found,
   output logic [4:0]       next_index
);

   // ----------------------------------------------------------------
   // Rotating search
   // ----------------------------------------------------------------
   // Searches from current+1 around to current itself, so one include
   // bit alone keeps being chosen.
   always_comb begin
      logic [4:0] cand;
      cand       = 5'h00;
      found      = 1'b0;
      next_index = 5'h00;
      for (int i = 1; i <= ais_pkg::NUM_INPUTS; i++) begin
         cand = current + i[4:0];
         if (!found && mask[cand]) begin
            found      = 1'b1;
            next_index = cand;
         end
      end
   end

endmodule : ais_scan_pick

// *** ais_top.sv ***
// Channel 0 input select and scan include registers behind an APB slave.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module ais_top (
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Part configuration
   input  wire logic [5:0]         pin_count,
   // Analog multiplexer
   output ais_pkg::ais_mux_type    mux_select,
   // Scan sequencer
   input  wire logic               scan_advance,
   output logic [31:0]             scan_include_bits,
   output ais_pkg::ais_scan_type   scan_current
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [15:0]           channel0_input_select;
   logic [15:0]           scan_include_high;
   logic [15:0]           scan_include_low;
   logic [15:0]           next_channel0_input_select;
   logic [15:0]           next_scan_include_high;
   logic [15:0]           next_scan_include_low;
   logic [31:0]           next_prdata;
   logic                  next_pready;
   logic                  next_pslverr;
   ais_pkg::ais_mux_type  next_mux_select;
   logic [31:0]           next_scan_include_bits;
   ais_pkg::ais_scan_type next_scan_current;
   logic                  pick_found;
   logic [4:0]            pick_index;
   logic                  access;
   logic                  mapped;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // One-wait slave: pready rises in the second access cycle.
   assign access = psel && penable && !pready;
   assign mapped = (paddr == ais_pkg::ADDR_CHANNEL0_INPUT_SELECT) ||
                   (paddr == ais_pkg::ADDR_SCAN_INCLUDE_HIGH) ||
                   (paddr == ais_pkg::ADDR_SCAN_INCLUDE_LOW) ||
                   (paddr == ais_pkg::ADDR_SCAN_STEP);

   ais_scan_pick u_pick (
      .mask       (next_scan_include_bits),
      .current    (scan_current.analog_input_n),
      .found      (pick_found),
      .next_index (pick_index)
   );

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      next_channel0_input_select = channel0_input_select;
      next_scan_include_high     = scan_include_high;
      next_scan_include_low      = scan_include_low;
      next_prdata                = 32'h0000_0000;
      next_pready                = access;
      next_pslverr               = access && !mapped;
      if (access && pwrite) begin
         case (paddr)
            ais_pkg::ADDR_CHANNEL0_INPUT_SELECT: begin
               next_channel0_input_select =
                  pwdata[15:0] & ais_pkg::SELECT_WRITE_MASK;
            end
            ais_pkg::ADDR_SCAN_INCLUDE_HIGH: begin
               next_scan_include_high = pwdata[15:0];
            end
            ais_pkg::ADDR_SCAN_INCLUDE_LOW: begin
               next_scan_include_low = pwdata[15:0];
            end
            default: begin
            end
         endcase
      end
      if (access && !pwrite) begin
         case (paddr)
            ais_pkg::ADDR_CHANNEL0_INPUT_SELECT: begin
               next_prdata = {16'h0000, channel0_input_select};
            end
            ais_pkg::ADDR_SCAN_INCLUDE_HIGH: begin
               next_prdata = {16'h0000, scan_include_high};
            end
            ais_pkg::ADDR_SCAN_INCLUDE_LOW: begin
               next_prdata = {16'h0000, scan_include_low};
            end
            ais_pkg::ADDR_SCAN_STEP: begin
               next_prdata = {25'h0000000, scan_current};
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs to the multiplexer and sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_mux_select.sample_a_positive_select =
         next_channel0_input_select[ais_pkg::POS_A_LSB +: 5];
      next_mux_select.sample_a_negative_select =
         next_channel0_input_select[ais_pkg::NEG_A_BIT];
      next_mux_select.sample_b_positive_select =
         next_channel0_input_select[ais_pkg::POS_B_LSB +: 5];
      next_mux_select.sample_b_negative_select =
         next_channel0_input_select[ais_pkg::NEG_B_BIT];
      next_scan_include_bits =
         {next_scan_include_high, next_scan_include_low};
      next_scan_current = scan_current;
      // An advance, an invalid selection or an excluded current input reselects; an empty mask idles.
      if (scan_advance || !scan_current.valid ||
          !next_scan_include_bits[scan_current.analog_input_n]) begin
         next_scan_current.valid          = pick_found;
         next_scan_current.analog_input_n = pick_found ? pick_index :
                                            5'h00;
      end
      // Inputs with no pin on this part convert the negative reference.
      next_scan_current.use_negative_reference =
         next_scan_current.valid &&
         ({1'b0, next_scan_current.analog_input_n} >= pin_count);
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel0_input_select <= ais_pkg::RESET_VALUE;
         scan_include_high     <= ais_pkg::RESET_VALUE;
         scan_include_low      <= ais_pkg::RESET_VALUE;
         prdata                <= 32'h0000_0000;
         pready                <= 1'b0;
         pslverr               <= 1'b0;
         mux_select            <= '0;
         scan_include_bits     <= 32'h0000_0000;
         scan_current          <= '0;
      end else begin
         channel0_input_select <= next_channel0_input_select;
         scan_include_high     <= next_scan_include_high;
         scan_include_low      <= next_scan_include_low;
         prdata                <= next_prdata;
         pready                <= next_pready;
         pslverr               <= next_pslverr;
         mux_select            <= next_mux_select;
         scan_include_bits     <= next_scan_include_bits;
         scan_current          <= next_scan_current;
      end
   end

endmodule : ais_top

// *** ais_chk.sv ***
// Concurrent checks on the ports of the channel select block.
`timescale 1ns/1ps
module ais_chk (
   // Clock and reset
   input wire logic                  pclk,
   input wire logic                  presetn,
   // APB slave
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [11:0]           paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   // Multiplexer and sequencer side
   input wire logic [5:0]            pin_count,
   input wire ais_pkg::ais_mux_type  mux_select,
   input wire logic                  scan_advance,
   input wire logic [31:0]           scan_include_bits,
   input wire ais_pkg::ais_scan_type scan_current
);
   // ----------------------------------------------------------------
   // Helpers and checks
   // ----------------------------------------------------------------
   logic        wt;
   logic [31:0] wd;
   assign wt = psel & penable & pwrite & ~pready;
   // Holding the taken write data avoids slicing a past value.
   always_ff @(posedge pclk) begin
      if (wt)
         wd <= pwdata;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_pos_a_neg: assert property (
      wt && paddr == 12'h000 |=> mux_select.sample_a_positive_select
      == wd[4:0] && mux_select.sample_a_negative_select == wd[7])
      else $error("sample A select differs from the write");
   chk_pos_b_neg: assert property (
      wt && paddr == 12'h000 |=> mux_select.sample_b_positive_select
      == wd[12:8] && mux_select.sample_b_negative_select == wd[15])
      else $error("sample B select differs from the write");
   chk_gap_zero: assert property (
      pready && !pwrite && paddr == 12'h000 |->
      prdata[14:13] == 2'h0 && prdata[6:5] == 2'h0)
      else $error("unimplemented select bits read nonzero");
   chk_reset_clear: assert property (
      $rose(presetn) |-> mux_select == '0 && scan_include_bits == '0)
      else $error("registers not clear after reset");
   chk_high_bits: assert property (
      wt && paddr == 12'h004 |=> scan_include_bits[31:16] == wd[15:0])
      else $error("high scan bits differ from the write");
   chk_low_bits: assert property (
      wt && paddr == 12'h008 |=> scan_include_bits[15:0] == wd[15:0])
      else $error("low scan bits differ from the write");
   chk_only_incl: assert property (
      $stable(scan_include_bits)[*3] ##0 scan_current.valid |->
      scan_include_bits[scan_current.analog_input_n])
      else $error("scan picked an excluded input");
   chk_neg_ref: assert property (
      scan_current.valid |-> scan_current.use_negative_reference ==
      ({1'b0, scan_current.analog_input_n} >= pin_count))
      else $error("negative reference flag wrong");
   cov_step: cover property (scan_advance && scan_current.valid);
   cov_err: cover property (pready && pslverr);
   cov_neg: cover property (scan_current.use_negative_reference);
endmodule : ais_chk
bind ais_top ais_chk ais_chk_inst (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_count,
   .mux_select, .scan_advance, .scan_include_bits, .scan_current);

// *** ais_seq_model.sv ***
// Scan sequencer model that steps the scan and records visited inputs.
`timescale 1ns/1ps
module ais_seq_model (
   // Clock and reset
   input wire logic                  pclk,
   input wire logic                  presetn,
   // Bench control and sequencer side
   input wire logic                  run,
   input wire ais_pkg::ais_scan_type cur,
   output logic                      scan_advance,
   output logic [31:0]               seen,
   output logic [31:0]               neg_seen
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn || !run) begin
         scan_advance <= 1'b0;
         seen         <= 32'h0;
         neg_seen     <= 32'h0;
      end else begin
         // Stepping every other cycle leaves a slot for reselection.
         scan_advance <= ~scan_advance;
         if (cur.valid) begin
            seen[cur.analog_input_n]     <= 1'b1;
            neg_seen[cur.analog_input_n] <= cur.use_negative_reference;
         end
      end
   end
endmodule : ais_seq_model

// *** adc_input_select_and_scan_mask_test.sv ***
// Self-checking bench for the channel select and scan include block.
`timescale 1ns/1ps
module adc_input_select_and_scan_mask_test;
   logic                  pclk = 1'b0;
   logic                  presetn = 1'b0;
   logic                  psel = 1'b0;
   logic                  penable = 1'b0;
   logic                  pwrite = 1'b0;
   logic [11:0]           paddr = 12'h000;
   logic [31:0]           pwdata = 32'h0;
   logic                  run = 1'b0;
   logic [31:0]           prdata, scan_include_bits, seen, neg_seen, q, x;
   logic                  pready, pslverr, scan_advance, e;
   ais_pkg::ais_mux_type  mux_select;
   ais_pkg::ais_scan_type scan_current;
   int                    err_total = 0;
   int                    checked = 0;
   logic [31:0]           vals [3] = '{32'hffffffff, 32'h1e1e, 32'h8001};
   always #25 pclk = ~pclk;
   // Only 18 inputs are bonded, so input 31 must convert the reference.
   ais_top ais_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_count(6'h12),
      .mux_select, .scan_advance, .scan_include_bits, .scan_current);
   ais_seq_model ais_seq_model_inst (.pclk, .presetn, .run,
      .cur(scan_current), .scan_advance, .seen, .neg_seen);
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rq, output logic re);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n == 20)
         err_total++;
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk(input logic [31:0] s, input logic [31:0] xp);
      checked++;
      if (s !== xp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, xp);
      end
   endtask : chk
   task automatic test_done;
      $display("checks=%0d mismatches=%0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0, q, e);
         chk(q, 32'h0);
      end
      $display("test reset values done");
      foreach (vals[i]) begin
         apb(1'b1, 12'h000, vals[i], q, e);
         x = {20'h0, vals[i][4:0], vals[i][7], vals[i][12:8], vals[i][15]};
         chk({20'h0, mux_select}, x);
         apb(1'b0, 12'h000, 32'h0, q, e);
         chk(q, vals[i] & 32'h9f9f);
      end
      $display("test channel select done");
      apb(1'b1, 12'h004, 32'hffffffff, q, e);
      apb(1'b0, 12'h004, 32'h0, q, e);
      chk(q, 32'h0000ffff);
      apb(1'b1, 12'h004, 32'h8001, q, e);
      apb(1'b1, 12'h008, 32'h0006, q, e);
      chk(scan_include_bits, 32'h80010006);
      run <= 1'b1;
      repeat (60) @(posedge pclk);
      chk(seen, 32'h80010006);
      chk(neg_seen, 32'h80000000);
      run <= 1'b0;
      // A single included input stays selected, and it has no pin here.
      apb(1'b1, 12'h008, 32'h0000, q, e);
      apb(1'b1, 12'h004, 32'h8000, q, e);
      apb(1'b1, 12'h00c, 32'hffffffff, q, e);
      chk({31'h0, e}, 32'h0);
      apb(1'b0, 12'h00c, 32'h0, q, e);
      chk(q, 32'h0000007f);
      $display("test scan done");
      apb(1'b1, 12'h010, 32'hffffffff, q, e);
      chk({31'h0, e}, 32'h1);
      apb(1'b0, 12'h010, 32'h0, q, e);
      chk(q, 32'h0);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h008, 32'h0, q, e);
      chk(q, 32'h0);
      $display("test error and second reset done");
      test_done();
   end
   initial begin
      // Several times the expected run length, so only a hang trips it.
      #50us;
      err_total++;
      test_done();
   end
endmodule : adc_input_select_and_scan_mask_test
